// ==== adc_serial_pkg.sv ====
// ==========================================================================
// Shared constants for the dual channel serial result port.
// ==========================================================================
package adc_serial_pkg;

  // Result word is both 16-bit channels back to back.
  localparam int CHAN_W = 16;
  localparam int RESULT_W = 2 * CHAN_W;
  localparam int BIT_CNT_W = 6;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RESET = 6'h00;
  localparam logic [BIT_CNT_W-1:0] CHAN_BITS = 6'h10;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 6'h1f;
  localparam logic [BIT_CNT_W-1:0] RESULT_BITS = 6'h20;
  localparam logic [BIT_CNT_W-1:0] BIT_STEP = 6'h01;

  // Each master bit is four quarter steps: data, clock high, high, low.
  localparam logic [1:0] PH_DATA = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  // Quarter step length is DIV_BASE shifted left by the divider setting.
  localparam int DIV_CNT_W = 4;
  localparam logic [DIV_CNT_W-1:0] DIV_BASE = 4'h1;
  localparam logic [DIV_CNT_W-1:0] DIV_CNT_RESET = 4'h0;
  localparam logic [DIV_CNT_W-1:0] DIV_STEP = 4'h1;

  // System clock and the least spacing of conversion clock ticks.
  localparam int CLK_PERIOD_NS = 100;
  localparam int MIN_TICK_GAP_NS = 400;
  localparam int MIN_TICK_GAP_CYC = (MIN_TICK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Master shift engine states.
  typedef enum logic {M_IDLE, M_SHIFT} master_state_t;

endpackage

// ==== result_shifter.sv ====
`timescale 1ns/1ns
// ==========================================================================
// Result shift register with chain capture.
// ==========================================================================
module result_shifter
  import adc_serial_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [RESULT_W-1:0] load_word,
  input wire logic capture,
  input wire logic chain_in,
  input wire logic shift,
  output logic bit_out
);

  logic [RESULT_W-1:0] word_ff;
  logic chain_ff;

  // The word shifts left; the captured chain bit enters at the bottom.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      word_ff <= '0;
    end else if (load) begin
      word_ff <= load_word;
    end else if (shift) begin
      word_ff <= {word_ff[RESULT_W-2:0], chain_ff};
    end
  end

  // Chain level is taken on the edge between two shifts.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      chain_ff <= 1'b0;
    end else if (capture) begin
      chain_ff <= chain_in;
    end
  end

  assign bit_out = word_ff[RESULT_W-1];

endmodule // result_shifter

// ==== adc_serial_port.sv ====
`timescale 1ns/1ns
// Summary of operation
// - Low source select: device makes clock, strobe.
// - Master clock and strobe polarity may invert.
// - Master data stable across both clock edges.
// - Timing input picks after or during conversion.
// - During-conversion strobe drops after channel LSB.
// - During-conversion clock follows conversion ticks.
// - After-conversion master: busy holds until shifted.
// - Divider input slows after-conversion master clock.
// - High source select: host supplies clock.
// - Slave clock ignored unless selected and enabled.
// - Slave accepts free or burst clock.
// - Slave after-conversion: 32 pulses, MSB first.
// - Slave after-conversion accepts slow to fast clocks.
// - Chain input only in slave after-conversion.
// - Chain bit taken on opposite clock edge.
// - Slave during-conversion shifts previous result out.
// - Unfinished read at conversion end pulses overrun.
// - Reads may finish after next conversion starts.
// - Serial port used when interface select high.
// - Channel order select picks first channel.
// - Deselect or read disable floats data output.
module adc_serial_port
  import adc_serial_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic interface_select,
  input wire logic clock_source_select,
  input wire logic read_timing_or_chain_input,
  input wire logic [1:0] shift_clock_divider,
  input wire logic clock_invert,
  input wire logic channel_order_select,
  input wire logic chip_select_n,
  input wire logic read_enable_n,
  input wire logic sclk_in,
  input wire logic conv_start,
  input wire logic conv_bit_tick,
  input wire logic conv_done,
  input wire logic [CHAN_W-1:0] result_a,
  input wire logic [CHAN_W-1:0] result_b,
  output logic busy,
  output logic serial_data_out,
  output logic sdo_oe_n,
  output logic sclk_out,
  output logic sclk_oe_n,
  output logic frame_valid_strobe,
  output logic read_overrun_flag
);

  // ========================================================================
  // Mode decode
  // ========================================================================
  master_state_t state_ff, nxt_state;
  logic [1:0] phase_ff, nxt_phase;
  logic [BIT_CNT_W-1:0] bit_cnt_ff, nxt_bit_cnt;
  logic [DIV_CNT_W-1:0] div_cnt_ff;
  logic busy_ff, sdo_ff, sdo_oe_n_ff, sclk_ff, sclk_oe_n_ff, fvs_ff, overrun_ff;
  logic sclk_prev_ff, parity_ff, started_ff, chain_act_ff;
  logic shift_bit;

  // The serial port is in use only when interface select is high.
  // serial port enable
  wire serial_on = interface_select;
  wire master_on = serial_on & !clock_source_select;
  wire slave_on = serial_on & clock_source_select;
  wire rdc_mode = read_timing_or_chain_input;
  wire master_rac = master_on & !rdc_mode;
  wire master_rdc = master_on & rdc_mode;
  wire bus_enabled = !chip_select_n & !read_enable_n;

  wire [RESULT_W-1:0] load_word = channel_order_select ? {result_a, result_b}
                                                       : {result_b, result_a};

  // ========================================================================
  // Master shift clock generation
  // ========================================================================
  // divider sets quarter step
  wire [DIV_CNT_W-1:0] div_len = DIV_BASE << shift_clock_divider;
  wire div_tick = (div_cnt_ff == div_len - DIV_STEP);
  wire m_go = master_rdc ? conv_bit_tick : div_tick;
  wire m_step = master_rdc ? 1'b1 : div_tick;
  wire m_shifting = (state_ff == M_SHIFT);
  wire m_shift = m_shifting & (phase_ff == PH_FALL) & m_step;
  wire m_last = m_shift & (bit_cnt_ff == LAST_BIT);
  wire m_start = master_rdc ? conv_start : (master_rac & conv_done);
  wire sclk_raw = m_shifting & ((phase_ff == PH_RISE) | (phase_ff == PH_HIGH));
  wire fvs_raw = m_shifting & !((phase_ff == PH_DATA) & (bit_cnt_ff == CHAN_BITS));

  // Divider free-runs so every quarter step after the first of a frame has the same length.
  always_ff @(posedge clk) begin
    if (!resetn || div_tick) begin
      div_cnt_ff <= DIV_CNT_RESET;
    end else begin
      div_cnt_ff <= div_cnt_ff + DIV_STEP;
    end
  end

  // Next master state: wait for a frame start, then walk the four phases.
  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    case (state_ff)
      M_IDLE: begin
        nxt_phase = PH_DATA;
        if (m_start) begin
          nxt_state = M_SHIFT;
        end
      end
      M_SHIFT: begin
        if (!master_on) begin
          nxt_state = M_IDLE;
        end else if (phase_ff == PH_DATA) begin
          if (m_go) begin
            nxt_phase = PH_RISE;
          end
        end else if (m_step) begin
          nxt_phase = phase_ff + 2'h1;
          if (m_last) begin
            nxt_state = M_IDLE;
          end
        end
      end
      default: begin
        nxt_state = M_IDLE;
        nxt_phase = PH_DATA;
      end
    endcase
  end

  // Master state registers.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= M_IDLE;
      phase_ff <= PH_DATA;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
    end
  end

  // ========================================================================
  // Slave shift clock handling
  // ========================================================================
  // clock counted only when selected
  wire s_en = slave_on & bus_enabled;
  // any edge counts, whatever idle level or slow rate
  wire s_edge = s_en & (sclk_in ^ sclk_prev_ff);
  // chain taken on the opposite edge
  wire s_capture = s_edge & !parity_ff;
  // stop after the last bit unless chaining
  wire s_more = chain_act_ff | (bit_cnt_ff < RESULT_BITS);
  // second edge of each pulse advances a bit
  wire s_shift = s_edge & parity_ff & s_more;
  // only conversion end can cut a read short
  wire overrun_hit = slave_on & conv_done & started_ff & (bit_cnt_ff < RESULT_BITS);

  // Previous clock level and edge parity within a pulse.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sclk_prev_ff <= 1'b0;
      parity_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= sclk_in;
      parity_ff <= s_en ? (parity_ff ^ s_edge) : 1'b0;
    end
  end

  // Read started flag and chaining, which only a read after conversion gets.
  always_ff @(posedge clk) begin
    if (!resetn || conv_done) begin
      started_ff <= 1'b0;
      chain_act_ff <= 1'b0;
    end else if (s_edge && !started_ff) begin
      started_ff <= 1'b1;
      // chain only when read after conversion
      chain_act_ff <= !busy_ff;
    end
  end

  // ========================================================================
  // Shared bit counter and shift register
  // ========================================================================
  assign shift_bit = master_on ? m_shift : s_shift;

  // Bit count restarts on a new result or a master frame; it saturates at 32.
  always_comb begin
    nxt_bit_cnt = bit_cnt_ff;
    if (conv_done || m_start) begin
      nxt_bit_cnt = BIT_CNT_RESET;
    end else if (shift_bit && bit_cnt_ff < RESULT_BITS) begin
      nxt_bit_cnt = bit_cnt_ff + BIT_STEP;
    end
  end

  // Bit counter register.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bit_cnt_ff <= BIT_CNT_RESET;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  logic shifter_msb;

  // previous result kept until next load
  result_shifter result_shifter_i (
    .clk(clk),
    .resetn(resetn),
    .load(conv_done),
    .load_word(load_word),
    .capture(s_capture),
    .chain_in(read_timing_or_chain_input),
    .shift(shift_bit),
    .bit_out(shifter_msb)
  );

  // ========================================================================
  // Busy and overrun
  // ========================================================================
  // after-conversion master keeps busy to the last bit
  wire busy_hold = master_rac & (conv_done | m_shifting);

  // Busy rises at conversion start and falls at its end or after the shift.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
    end else if (conv_start) begin
      busy_ff <= 1'b1;
    end else if (busy_hold) begin
      busy_ff <= !m_last;
    end else if (conv_done) begin
      busy_ff <= 1'b0;
    end
  end

  // Overrun is a single cycle pulse.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      overrun_ff <= 1'b0;
    end else begin
      overrun_ff <= overrun_hit;
    end
  end

  // ========================================================================
  // Pin registers
  // ========================================================================
  // optional clock and strobe inversion
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sclk_ff <= 1'b0;
      fvs_ff <= 1'b0;
      sclk_oe_n_ff <= 1'b1;
    end else begin
      sclk_ff <= sclk_raw ^ clock_invert;
      fvs_ff <= fvs_raw ^ clock_invert;
      sclk_oe_n_ff <= !master_on;
    end
  end

  // master data changes only with the raw clock low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sdo_ff <= 1'b0;
      sdo_oe_n_ff <= 1'b1;
    end else begin
      sdo_ff <= shifter_msb;
      sdo_oe_n_ff <= !(serial_on & bus_enabled);
    end
  end

  assign busy = busy_ff;
  assign serial_data_out = sdo_ff;
  assign sdo_oe_n = sdo_oe_n_ff;
  assign sclk_out = sclk_ff;
  assign sclk_oe_n = sclk_oe_n_ff;
  assign frame_valid_strobe = fvs_ff;
  assign read_overrun_flag = overrun_ff;

  // ========================================================================
  // Assertions
  // ========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_master_drives; master_on |=> !sclk_oe_n; endproperty
  a_master_drives: assert property (p_master_drives) else $error("clock not driven");
  property p_idle_level; master_on && !m_shifting |=> sclk_out == $past(clock_invert);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle polarity wrong");
  property p_data_stable; master_on && $changed(sclk_out) |-> $stable(serial_data_out);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved at edge");
  property p_fvs_drop; master_rdc && m_shift && (bit_cnt_ff == CHAN_BITS - BIT_STEP
    || bit_cnt_ff == LAST_BIT) |=> ##1 frame_valid_strobe == $past(clock_invert); endproperty
  a_fvs_drop: assert property (p_fvs_drop) else $error("strobe held after lsb");
  property p_rdc_wait; master_rdc && m_shifting && phase_ff == PH_DATA && !conv_bit_tick
    |=> phase_ff == PH_DATA; endproperty
  a_rdc_wait: assert property (p_rdc_wait) else $error("bit without tick");
  property p_busy_hold; master_rac && conv_done && !conv_start |=> busy [*2]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy fell early");
  property p_div_wait; master_rac && m_shifting && phase_ff == PH_RISE && !div_tick
    |=> phase_ff == PH_RISE; endproperty
  a_div_wait: assert property (p_div_wait) else $error("divider ignored");
  property p_slave_float; slave_on |=> sclk_oe_n; endproperty
  a_slave_float: assert property (p_slave_float) else $error("slave drove clock");
  property p_gate; slave_on && !bus_enabled && !conv_done |=> $stable(bit_cnt_ff);
  endproperty
  a_gate: assert property (p_gate) else $error("clock not gated");
  property p_overrun; overrun_hit |=> read_overrun_flag ##1 !read_overrun_flag;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun pulse wrong");
  property p_hold; slave_on && !chain_act_ff && bit_cnt_ff == RESULT_BITS && !conv_done
    |=> ##1 $stable(serial_data_out); endproperty
  a_hold: assert property (p_hold) else $error("data moved after last bit");
  property p_float; !bus_enabled |=> sdo_oe_n; endproperty
  a_float: assert property (p_float) else $error("data not floated");

  c_master_frame: cover property (m_last);
  c_slave_full: cover property (s_shift && bit_cnt_ff == LAST_BIT);
  c_overrun: cover property (overrun_hit);
  c_chain: cover property (chain_act_ff && bit_cnt_ff == RESULT_BITS && s_shift);

endmodule // adc_serial_port

// ==== serial_host_model.sv ====
`timescale 1ns/1ns
// ==========================================================================
// Host that reads results with its own burst shift clock.
// ==========================================================================
module serial_host_model (
  input wire logic clk,
  input wire logic start,
  input wire logic sel,
  input wire logic noise,
  input wire logic idle_hi,
  input wire logic [3:0] half,
  input wire logic [6:0] npulse,
  input wire logic serial_data_out,
  input wire logic sdo_oe_n,
  output logic sclk_in,
  output logic chip_select_n,
  output logic read_enable_n,
  output logic [31:0] word,
  output logic done
);
  logic [2:0] ph = 3'h0;
  logic line;

  // A released data line shows a level that flips every cycle.
  always @(posedge clk) ph <= ph + 3'h1;
  assign line = sdo_oe_n ? ph[0] : serial_data_out;

  // Idle clock stands at its idle level; noise toggles it between bursts.
  // select, burst clock
  initial begin
    sclk_in = 1'b0;
    chip_select_n = 1'b1;
    read_enable_n = 1'b0;
    word = 32'h0;
    done = 1'b0;
    forever begin
      @(posedge clk);
      done <= 1'b0;
      chip_select_n <= !sel;
      read_enable_n <= 1'b0;
      sclk_in <= noise ? ph[2] : idle_hi;
      if (start) begin
        chip_select_n <= 1'b0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < npulse; i++) begin
          word <= {word[30:0], line};
          sclk_in <= !idle_hi;
          repeat (half) @(posedge clk);
          sclk_in <= idle_hi;
          repeat (half) @(posedge clk);
        end
        done <= 1'b1;
      end
    end
  end
endmodule // serial_host_model

// ==== adc_serial_port_bench.sv ====
`timescale 1ns/1ns
// ==========================================================================
// Self-checking bench for the serial result port.
// ==========================================================================
module adc_serial_port_bench;
  import adc_serial_pkg::*;
  logic clk, resetn, interface_select, clock_source_select, read_timing_or_chain_input;
  logic [1:0] shift_clock_divider;
  logic clock_invert, channel_order_select, sclk_in, chip_select_n, read_enable_n;
  logic conv_start, conv_bit_tick, conv_done, busy, serial_data_out, sdo_oe_n;
  logic sclk_out, sclk_oe_n, frame_valid_strobe, read_overrun_flag, cb;
  logic [CHAN_W-1:0] result_a, result_b;
  logic h_start, h_sel, h_noise, h_idle, h_done, mclk_d, gd1, gd2, skip;
  logic [3:0] h_half;
  logic [6:0] h_np;
  logic [31:0] h_word;
  logic [RESULT_W-1:0] expq[$];
  logic [RESULT_W-1:0] last_w, mword;
  int n_fail, tests_run, cyc, mcnt, last_rise, n_ovr, o;

  // Free running system clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  adc_serial_port adc_serial_port_i (.clk, .resetn, .interface_select, .clock_source_select,
    .read_timing_or_chain_input, .shift_clock_divider, .clock_invert, .channel_order_select,
    .chip_select_n, .read_enable_n, .sclk_in, .conv_start, .conv_bit_tick, .conv_done,
    .result_a, .result_b, .busy, .serial_data_out, .sdo_oe_n, .sclk_out, .sclk_oe_n,
    .frame_valid_strobe, .read_overrun_flag);

  serial_host_model serial_host_model_i (.clk, .start(h_start), .sel(h_sel), .noise(h_noise),
    .idle_hi(h_idle), .half(h_half), .npulse(h_np), .serial_data_out, .sdo_oe_n, .sclk_in,
    .chip_select_n, .read_enable_n, .word(h_word), .done(h_done));

  // ==========================================================================
  // Shared tasks.
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic note(input string s);
    $display("Test %s finished, mismatches so far %0d", s, n_fail);
  endtask

  task automatic take(input logic [31:0] got);
    if (expq.size() == 0) chk(32'h1, 32'h0, "result not expected");
    else chk(got, expq.pop_front(), "result word");
  endtask

  task automatic conv_begin();
    @(posedge clk) conv_start <= 1'b1;
    @(posedge clk) conv_start <= 1'b0;
  endtask

  // New random results; the expected word puts the selected channel first.
  task automatic conv_end(input bit push);
    logic [CHAN_W-1:0] a, b;
    a = CHAN_W'($urandom);
    b = CHAN_W'($urandom);
    last_w = channel_order_select ? {a, b} : {b, a};
    if (push) expq.push_back(last_w);
    @(posedge clk);
    conv_done <= 1'b1;
    result_a <= a;
    result_b <= b;
    @(posedge clk) conv_done <= 1'b0;
  endtask

  task automatic host_go(input int n);
    @(posedge clk);
    h_np <= n[6:0];
    h_start <= 1'b1;
    @(posedge clk) h_start <= 1'b0;
  endtask

  // Waits for the host to finish, or for busy to fall, under a bound.
  task automatic wait_on(input bit host);
    int k;
    k = 0;
    while ((host ? h_done !== 1'b1 : busy !== 1'b0) && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk(k < 3000, 32'h1, "wait bound");
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Monitors: master bits, floated data line, overrun pulses, host words.
  // ==========================================================================
  always @(posedge clk) begin
    cyc <= cyc + 1;
    mclk_d <= sclk_out ^ clock_invert;
    gd1 <= !interface_select || chip_select_n || read_enable_n;
    gd2 <= gd1;
    if (resetn && gd1 && gd2) chk(sdo_oe_n, 32'h1, "data line driven");
    if (read_overrun_flag === 1'b1) n_ovr++;
    if (h_done === 1'b1 && !skip) take(h_word);
    if (resetn && sclk_oe_n === 1'b0 && !mclk_d && (sclk_out ^ clock_invert) === 1'b1) begin
      if (!read_timing_or_chain_input && mcnt > 0) begin
        chk(cyc - last_rise, 4 << shift_clock_divider, "shift period");
      end
      last_rise = cyc;
      chk(frame_valid_strobe ^ clock_invert, 32'h1, "strobe during bit");
      mword = {mword[30:0], serial_data_out};
      mcnt++;
      if (mcnt == 32) begin
        mcnt = 0;
        take(mword);
      end
    end
    if (cyc > 20000) begin
      n_fail++;
      $display("[ERR] %0t run did not finish", $time);
      wrap_up();
    end
  end

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    {resetn, read_timing_or_chain_input, shift_clock_divider, clock_invert} = '0;
    {channel_order_select, conv_start, conv_bit_tick, conv_done, result_a, result_b} = '0;
    {h_start, h_noise, h_idle, h_sel, mclk_d, gd1, gd2, skip} = '0;
    {interface_select, clock_source_select} = 2'h3;
    h_half = 4'h4;
    h_np = 7'h20;
    {n_fail, tests_run, cyc, mcnt, last_rise, n_ovr} = '0;
    void'($urandom(32'he40b));
    tick(6);
    resetn <= 1'b1;
    chk({busy, sdo_oe_n, sclk_oe_n, read_overrun_flag}, 32'h6, "reset outputs");
    tick(2);
    for (int i = 0; i < 4; i++) begin
      channel_order_select <= i[0];
      h_idle <= i[1];
      h_half <= 4'(4 + $urandom_range(2));
      tick(2);
      conv_begin();
      tick(8);
      conv_end(1'b1);
      tick(3);
      chk(busy, 32'h0, "busy after done");
      host_go(32);
      wait_on(1'b1);
    end
    note("slave read after conversion");
    cb = 1'($urandom);
    read_timing_or_chain_input <= cb;
    conv_begin();
    tick(8);
    conv_end(1'b0);
    expq.push_back({last_w[23:0], {8{cb}}});
    h_noise <= 1'b1;
    tick(40);
    h_noise <= 1'b0;
    tick(2);
    host_go(40);
    wait_on(1'b1);
    read_timing_or_chain_input <= 1'b0;
    note("chain and deselected clock");
    conv_end(1'b0);
    o = n_ovr;
    conv_begin();
    tick(2);
    expq.push_back(last_w);
    host_go(32);
    wait_on(1'b1);
    conv_end(1'b0);
    tick(3);
    expq.push_back(last_w);
    host_go(32);
    tick(30);
    conv_begin();
    wait_on(1'b1);
    conv_end(1'b0);
    tick(3);
    chk(n_ovr, o, "spurious overrun");
    skip = 1'b1;
    h_half <= 4'h8;
    conv_begin();
    tick(2);
    host_go(32);
    tick(60);
    conv_end(1'b0);
    tick(3);
    chk(n_ovr, o + 1, "overrun pulse");
    wait_on(1'b1);
    interface_select <= 1'b0;
    host_go(8);
    wait_on(1'b1);
    conv_end(1'b0);
    interface_select <= 1'b1;
    tick(2);
    skip = 1'b0;
    note("slave read during conversion and overrun");
    clock_invert <= 1'b1;
    h_sel <= 1'b1;
    read_timing_or_chain_input <= 1'b1;
    tick(2);
    clock_source_select <= 1'b0;
    tick(3);
    conv_begin();
    expq.push_back(last_w);
    repeat (32) begin
      tick(5);
      conv_bit_tick <= 1'b1;
      tick(1);
      conv_bit_tick <= 1'b0;
    end
    tick(8);
    conv_end(1'b0);
    tick(2);
    chk(mcnt, 32'h0, "bits in frame");
    clock_source_select <= 1'b1;
    tick(2);
    clock_invert <= 1'b0;
    read_timing_or_chain_input <= 1'b0;
    tick(2);
    clock_source_select <= 1'b0;
    note("master read during conversion");
    for (int d = 0; d < 4; d++) begin
      shift_clock_divider <= d[1:0];
      channel_order_select <= 1'($urandom);
      tick(2);
      conv_begin();
      tick(6);
      conv_end(1'b1);
      tick(6);
      chk(busy, 32'h1, "busy held");
      wait_on(1'b0);
      tick(2);
      chk(mcnt, 32'h0, "bits in frame");
    end
    note("master read after conversion");
    chk(expq.size(), 32'h0, "results missing");
    wrap_up();
  end
endmodule // adc_serial_port_bench
